/* host_irq_model.sv */
/*
  Host side of the interrupt request lines: picks the highest-ranked
  asserted line. Assumes active-low request lines, one per level.
*/
`timescale 1ns/1ns
module host_irq_model
  import irq_sel_pkg::*;
(
  input wire logic [irq_sel_pkg::LINES-1:0] irq_line_n,
  output irq_sel_pkg::level_t top_level,
  output logic req_seen
);
  // rank by code
  // Scan from lowest rank so the last hit is the highest ranked
  always_comb begin
    top_level = 4'h0;
    req_seen = 1'b0;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (irq_line_n[i] === 1'b0) begin
        top_level = LEVEL_MAP[i];
        req_seen = 1'b1;
      end
    end
  end
endmodule

/* irq_level_select.sv */
/*
  Adapter interrupt level select: pending latch, status/clear register,
  level select and one active-low request line per host level, with an
  AXI4-Lite slave and a masked event interrupt.
  Assumes request and channel reset arrive asynchronously on pins.
*/
`timescale 1ns/1ns
module irq_level_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [irq_sel_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [irq_sel_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic adapter_irq_request_n,
  input wire logic host_channel_reset,
  output logic [irq_sel_pkg::LINES-1:0] irq_line_n,
  output logic irq_out
);
  import irq_sel_pkg::*;

  logic [1:0] sync_out;
  logic req_n_s;
  logic chres_s;
  logic chres_d_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_got_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_got_r;
  logic wr_do;
  logic wr_hit;
  logic clr_wr;
  logic pending_r;
  logic [SEL_W-1:0] select_r;
  logic [EV_W-1:0] event_r;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_w1c;
  logic [31:0] rd_data;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(2),
    .RESET_VAL(PIN_RST)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({host_channel_reset, adapter_irq_request_n}),
    .pin_out(sync_out)
  );
  assign req_n_s = sync_out[0];
  assign chres_s = sync_out[1];

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign wr_do = aw_got_r && w_got_r && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
      aw_got_r <= 1'b0;
      awready <= 1'b1;
    end else if (awvalid && awready) begin
      awaddr_r <= awaddr;
      aw_got_r <= 1'b1;
      awready <= 1'b0;
    end else if (wr_do) begin
      aw_got_r <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_r <= '0;
      wstrb_r <= '0;
      w_got_r <= 1'b0;
      wready <= 1'b1;
    end else if (wvalid && wready) begin
      wdata_r <= wdata;
      wstrb_r <= wstrb;
      w_got_r <= 1'b1;
      wready <= 1'b0;
    end else if (wr_do) begin
      w_got_r <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (awaddr_r)
      STATUS_OFS, SELECT_OFS, LEVEL_OFS, EVENT_OFS, MASK_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending latch
  // ----------------------------------------------------------------
  // clear on zero
  assign clr_wr = wr_do && (awaddr_r == STATUS_OFS) && wstrb_r[0] && !wdata_r[STATUS_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn || chres_s) begin
      pending_r <= 1'b0;
    // request sets, wins over a clear
    end else if (!req_n_s) begin
      pending_r <= 1'b1;
    end else if (clr_wr) begin
      pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_r <= SELECT_RST;
    end else if (wr_do && (awaddr_r == SELECT_OFS) && wstrb_r[0]) begin
      select_r <= wdata_r[SEL_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RST;
    end else if (wr_do && (awaddr_r == MASK_OFS) && wstrb_r[0]) begin
      mask_r <= wdata_r[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky events and interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chres_d_r <= 1'b0;
    end else begin
      chres_d_r <= chres_s;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[EV_LATCH_BIT] = !pending_r && !req_n_s && !chres_s;
    ev_set[EV_CHRES_BIT] = chres_s && !chres_d_r;
    ev_w1c = '0;
    if (wr_do && (awaddr_r == EVENT_OFS) && wstrb_r[0]) begin
      ev_w1c = wdata_r[EV_W-1:0];
    end
  end

  // New event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= EVENT_RST;
    end else begin
      event_r <= (event_r & ~ev_w1c) | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(event_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Host request lines
  // ----------------------------------------------------------------
  // Selected line is driven low only while pending; others stay inactive high
  for (genvar i = 0; i < LINES; i++) begin : g_line
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        irq_line_n[i] <= 1'b1;
      end else begin
        irq_line_n[i] <= !(pending_r && (select_r == SEL_W'(i)));
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (araddr)
      STATUS_OFS: rd_data[STATUS_BIT] = !pending_r;
      SELECT_OFS: rd_data[SEL_W-1:0] = select_r;
      LEVEL_OFS: begin
        rd_data[LVL_W-1:0] = LEVEL_MAP[select_r];
        rd_data[LINE_ON_BIT] = !irq_line_n[select_r];
      end
      EVENT_OFS: rd_data[EV_W-1:0] = event_r;
      MASK_OFS: rd_data[EV_W-1:0] = mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_status_read;
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == STATUS_OFS)
      |=> rvalid && (rdata[STATUS_BIT] == !$past(pending_r));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status bit does not show latch state");

  property p_chres_idle;
    @(posedge aclk) disable iff (!aresetn)
      chres_s |=> !pending_r ##1 (&irq_line_n);
  endproperty
  a_chres_idle: assert property (p_chres_idle)
    else $error("channel reset did not idle the latch");

  property p_clear_write;
    @(posedge aclk) disable iff (!aresetn)
      (clr_wr && req_n_s && !chres_s) |=> !pending_r ##1 (&irq_line_n);
  endproperty
  a_clear_write: assert property (p_clear_write)
    else $error("writing zero did not clear the latch");

  property p_req_sets;
    @(posedge aclk) disable iff (!aresetn)
      (!req_n_s && !chres_s) |=> pending_r ##1 !irq_line_n[$past(select_r)];
  endproperty
  a_req_sets: assert property (p_req_sets)
    else $error("request did not set latch and line");

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> bvalid && $stable(bresp) && !awready && !wready;
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");

  property p_line_map;
    @(posedge aclk) disable iff (!aresetn)
      pending_r |=> (irq_line_n == ~(8'h01 << $past(select_r)));
  endproperty
  a_line_map: assert property (p_line_map)
    else $error("wrong request line for select code");

  property p_one_line;
    @(posedge aclk) disable iff (!aresetn)
      $countones(~irq_line_n) <= 1;
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("more than one request line asserted");

  property p_idle_lines;
    @(posedge aclk) disable iff (!aresetn)
      !pending_r |=> (&irq_line_n);
  endproperty
  a_idle_lines: assert property (p_idle_lines)
    else $error("line asserted with nothing pending");
endmodule

/* irq_sel_pkg.sv */
/*
  Shared constants for the adapter interrupt level select block:
  register offsets, field positions, reset values and the level map.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package irq_sel_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SELECT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LEVEL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h10;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int STATUS_BIT = 0;
  localparam int SEL_W = 3;
  localparam int LINES = 8;
  localparam int LVL_W = 4;
  localparam int LINE_ON_BIT = 8;
  localparam int EV_W = 2;
  localparam int EV_LATCH_BIT = 0;
  localparam int EV_CHRES_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SELECT_RST = 3'h0;
  localparam logic [EV_W-1:0] EVENT_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
  // Pin synchroniser idle: request high (inactive), channel reset low
  localparam logic [1:0] PIN_RST = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Host interrupt level for each select code
  typedef logic [LVL_W-1:0] level_t;
  localparam level_t LEVEL_MAP [LINES] = '{4'hA, 4'hB, 4'hC, 4'h3,
                                           4'h4, 4'h5, 4'h6, 4'h7};
endpackage

/* pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for asynchronous pins.
  Assumes pins are unrelated to aclk; output moves only when stages
  two and three agree.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_r[i] <= RESET_VAL[i];
        s2_r[i] <= RESET_VAL[i];
        s3_r[i] <= RESET_VAL[i];
        pin_out[i] <= RESET_VAL[i];
      end else begin
        s1_r[i] <= pin_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        // Glitch of one cycle never reaches the output
        if (s2_r[i] == s3_r[i]) begin
          pin_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

/* tb_adapter_interrupt_level_select.sv */
/*
  Self-checking bench for the interrupt level select block.
  Assumes an AXI4-Lite slave that answers in its own time and pins
  that pass a three-stage synchroniser before they reach the latch.
*/
`timescale 1ns/1ns
module tb_adapter_interrupt_level_select;
  import irq_sel_pkg::*;
  typedef struct {logic [2:0] sel; level_t lvl; logic [7:0] lines;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'hF;
  logic req_n = 1'b1, chres = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_out, req_seen;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [7:0] irq_line_n;
  level_t top_level;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  row_t rows [8] = '{'{3'h0, 4'hA, 8'hFE}, '{3'h1, 4'hB, 8'hFD}, '{3'h2, 4'hC, 8'hFB},
    '{3'h3, 4'h3, 8'hF7}, '{3'h4, 4'h4, 8'hEF}, '{3'h5, 4'h5, 8'hDF},
    '{3'h6, 4'h6, 8'hBF}, '{3'h7, 4'h7, 8'h7F}};

  always #4 aclk = ~aclk;

  irq_level_select i_irq_level_select (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .adapter_irq_request_n(req_n), .host_channel_reset(chres),
    .irq_line_n(irq_line_n), .irq_out(irq_out));
  host_irq_model i_host_irq_model (.irq_line_n(irq_line_n), .top_level(top_level),
    .req_seen(req_seen));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pin_wait();
    repeat (8) @(posedge aclk);
    #1;
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling well above the several hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("lines after reset", 32'hFF, {24'h0, irq_line_n});
    chk("irq_out after reset", 32'h0, {31'h0, irq_out});
    rdw(STATUS_OFS);
    chk("status after reset", 32'h1, rd);
    rdw(SELECT_OFS);
    chk("select reset", 32'h0, rd);
    rdw(MASK_OFS);
    chk("mask reset", 32'h0, rd);
    wr(8'h20, 32'h1);
    chk("unmapped write resp", 32'h2, {30'h0, rsp});
    rdw(8'h20);
    chk("unmapped read resp", 32'h2, {30'h0, rsp});
    chk("unmapped read data", 32'h0, rd);
    foreach (rows[i]) begin
      wr(SELECT_OFS, {29'h0, rows[i].sel});
      req_n <= 1'b0;
      pin_wait();
      chk("selected lines", {24'h0, rows[i].lines}, {24'h0, irq_line_n});
      chk("host level", {28'h0, rows[i].lvl}, {28'h0, top_level});
      rdw(LEVEL_OFS);
      chk("level reg", {23'h0, 1'b1, 4'h0, rows[i].lvl}, rd);
      rdw(STATUS_OFS);
      chk("status pending", 32'h0, rd);
      req_n <= 1'b1;
      pin_wait();
      chk("held after request", {24'h0, rows[i].lines}, {24'h0, irq_line_n});
      wr(STATUS_OFS, 32'h0);
      pin_wait();
      chk("lines cleared", 32'hFF, {24'h0, irq_line_n});
      rdw(STATUS_OFS);
      chk("status cleared", 32'h1, rd);
    end
    // Clear refused while the request pin is still low
    req_n <= 1'b0;
    pin_wait();
    wr(STATUS_OFS, 32'h0);
    pin_wait();
    rdw(STATUS_OFS);
    chk("clear with request low", 32'h0, rd);
    chk("one line only", 32'h7F, {24'h0, irq_line_n});
    chres <= 1'b1;
    pin_wait();
    chk("lines in channel reset", 32'hFF, {24'h0, irq_line_n});
    rdw(STATUS_OFS);
    chk("status in channel reset", 32'h1, rd);
    req_n <= 1'b1;
    chres <= 1'b0;
    pin_wait();
    chk("no host request", 32'h0, {31'h0, req_seen});
    // Event, mask and clear of the interrupt output
    rdw(EVENT_OFS);
    chk("events seen", 32'h3, rd);
    chk("masked irq_out", 32'h0, {31'h0, irq_out});
    wr(MASK_OFS, 32'h2);
    pin_wait();
    chk("unmasked irq_out", 32'h1, {31'h0, irq_out});
    wr(EVENT_OFS, 32'h2);
    pin_wait();
    chk("cleared irq_out", 32'h0, {31'h0, irq_out});
    rdw(EVENT_OFS);
    chk("event after w1c", 32'h1, rd);
    wr(MASK_OFS, 32'h1);
    pin_wait();
    chk("latch event irq_out", 32'h1, {31'h0, irq_out});
    // Ignored writes: byte lane 0 off, and the read-only level word
    wr(SELECT_OFS, 32'h5);
    chk("select write resp", 32'h0, {30'h0, rsp});
    wstrb <= 4'hE;
    wr(SELECT_OFS, 32'h7);
    wstrb <= 4'hF;
    chk("lane off write resp", 32'h0, {30'h0, rsp});
    wr(LEVEL_OFS, 32'h0);
    chk("level write resp", 32'h0, {30'h0, rsp});
    rdw(SELECT_OFS);
    chk("select kept", 32'h5, rd);
    chk("select read resp", 32'h0, {30'h0, rsp});
    req_n <= 1'b0;
    pin_wait();
    req_n <= 1'b1;
    pin_wait();
    chk("line before reset", 32'hDF, {24'h0, irq_line_n});
    // Reset in mid-run while a line is asserted
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("lines after mid reset", 32'hFF, {24'h0, irq_line_n});
    chk("irq_out after mid reset", 32'h0, {31'h0, irq_out});
    rdw(STATUS_OFS);
    chk("status after mid reset", 32'h1, rd);
    rdw(SELECT_OFS);
    chk("select after mid reset", 32'h0, rd);
    rdw(MASK_OFS);
    chk("mask after mid reset", 32'h0, rd);
    rdw(EVENT_OFS);
    chk("events after mid reset", 32'h0, rd);
    print_verdict();
  end
endmodule
